//--- logic/czd_pkg.sv
// Constants and types shared by the core address zone decoder
//
// Behaviour
// - Boot-ROM variant: 1 Mbyte expansion memory aliased below and above 0x100000.
// - Addresses 0x00F900 to 0x00F90A decode as shared BIOS and security registers.
// - Split registers: read returns one register, write updates another.
// - Write-one-to-clear bits: written one clears, written zero leaves unchanged.
// - Byte and word transactions accepted anywhere inside memory regions.
// - Reserved bits written as zero or read-back value; reads undefined.
// - Base memory 0x000000 to 0x01FFFF is the fast zone, zone 1 timing.
// - Base memory 0x020000 to 0x0FFFFF is the slow zone, zone 2 timing.
// - Internal-run and on-board-debug serve base memory on-chip, zone timing kept.
// - Flash variants off-chip environment: off-chip base memory spans 1016 Kbytes.
// - Boot-ROM variant off-chip environment: off-chip base memory only 4 Kbytes.
package czd_pkg;

    // ------------------------------------------------------------
    // Variants and modes
    // ------------------------------------------------------------
    localparam int VAR_FLASH64 = 0;
    localparam int VAR_FLASH128 = 1;
    localparam int VAR_BOOTROM = 2;
    localparam int ADDR_W = 21;

    typedef enum logic [1:0] {internal_run_env, onboard_debug_env, offchip_code_env} czd_env_t;

    typedef enum logic [3:0] {rgn_reserved, rgn_base, rgn_exp, rgn_ram, rgn_flash_ctl,
        rgn_shbios, rgn_biu, rgn_dma, rgn_ioexp, rgn_modreg} czd_region_t;

    typedef enum logic [1:0] {acc_rw, acc_ro, acc_split, acc_w1c} czd_acc_t;

    // ------------------------------------------------------------
    // Address map
    // ------------------------------------------------------------
    localparam logic [20:0] BOOT_BASE_TOP = 21'h000FFF;
    localparam logic [20:0] BASE_LOW_TOP = 21'h00DFFF;
    localparam logic [20:0] RAM_LO_BIG = 21'h00E800;
    localparam logic [20:0] RAM_LO_SMALL = 21'h00F000;
    localparam logic [20:0] RAM_TOP = 21'h00F7FF;
    localparam logic [20:0] FCTL_LO = 21'h00F880;
    localparam logic [20:0] FCTL_TOP = 21'h00F8FF;
    localparam logic [20:0] SHB_LO = 21'h00F900;
    localparam logic [20:0] SHB_TOP = 21'h00F90A;
    localparam logic [20:0] BIU_LO = 21'h00F980;
    localparam logic [20:0] BIU_TOP = 21'h00F98F;
    localparam logic [20:0] DMA_LO = 21'h00FA00;
    localparam logic [20:0] DMA_TOP = 21'h00FA7F;
    localparam logic [20:0] IOX_LO = 21'h00FB00;
    localparam logic [20:0] IOX_TOP = 21'h00FBFF;
    localparam logic [20:0] MOD_LO = 21'h00FC00;
    localparam logic [20:0] LOW64_TOP = 21'h00FFFF;
    localparam logic [20:0] FAST_TOP = 21'h01FFFF;
    localparam logic [20:0] BASE_TOP = 21'h0FFFFF;

    // ------------------------------------------------------------
    // Shared BIOS register block
    // ------------------------------------------------------------
    localparam int SHB_COUNT = 11;
    localparam int SHB_STATUS = 0;
    localparam int SHB_SPLIT = 1;
    localparam int SHB_INFO = 2;
    localparam logic [7:0] SHB_RST = 8'h00;

endpackage : czd_pkg

//--- logic/czd_reg_cell.sv
// One byte-wide register cell with selectable access type
module czd_reg_cell #(
    parameter czd_pkg::czd_acc_t ACC = czd_pkg::acc_rw
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic clk_en,
    input wire logic wr,
    input wire logic [7:0] wdata,
    input wire logic [7:0] hw_set,
    input wire logic [7:0] rd_src,
    output logic [7:0] rdata,
    output logic [7:0] store_r
);

    logic [7:0] store_nxt;

    // ------------------------------------------------------------
    // Next value per access type
    // ------------------------------------------------------------
    always_comb
    begin
        store_nxt = store_r;
        case (ACC)
            czd_pkg::acc_rw:
            begin
                if (wr) store_nxt = wdata;
            end
            czd_pkg::acc_split:
            begin
                if (wr) store_nxt = wdata;
            end
            czd_pkg::acc_w1c:
            begin
                // Hardware set wins over a clear in the same cycle
                if (wr) store_nxt = store_r & ~wdata;
                store_nxt = store_nxt | hw_set;
            end
            default:
            begin
                store_nxt = store_r;
            end
        endcase
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst) store_r <= czd_pkg::SHB_RST;
        else if (clk_en) store_r <= store_nxt;
    end

    // Split and read-only cells show another source on read
    assign rdata = (ACC == czd_pkg::acc_split || ACC == czd_pkg::acc_ro) ? rd_src : store_r;

endmodule : czd_reg_cell

//--- logic/czd_decoder.sv
// Core address zone decoder with shared BIOS register block
module czd_decoder #(
    parameter int VARIANT = czd_pkg::VAR_FLASH64
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic clk_en,
    input wire logic core_req,
    input wire logic [20:0] core_addr,
    input wire logic core_we,
    input wire logic core_word,
    input wire logic [15:0] core_wdata,
    input wire czd_pkg::czd_env_t env_mode,
    output logic dec_valid_r,
    output logic [3:0] region_r,
    output logic base_fast_r,
    output logic base_slow_r,
    output logic base_onchip_r,
    output logic base_offchip_r,
    output logic exp_sel_r,
    output logic [20:0] mem_offset_r,
    output logic reserved_hit_r,
    output logic width_err_r,
    output logic [15:0] core_rdata_r,
    output logic [7:0] shbios_ctl
);

    // ------------------------------------------------------------
    // Elaboration check
    // ------------------------------------------------------------
    generate
        if (VARIANT < czd_pkg::VAR_FLASH64 || VARIANT > czd_pkg::VAR_BOOTROM)
        begin : g_bad_variant
            $error("czd_decoder: VARIANT out of range");
        end
    endgenerate

    localparam logic IS_BOOT = (VARIANT == czd_pkg::VAR_BOOTROM);
    localparam logic IS_BIG = (VARIANT == czd_pkg::VAR_FLASH128);
    localparam logic [20:0] RAM_LO = IS_BIG ? czd_pkg::RAM_LO_BIG : czd_pkg::RAM_LO_SMALL;

    czd_pkg::czd_region_t rgn_nxt;
    logic dev_env;
    logic in_base;
    logic shb_hit;
    logic [3:0] shb_idx;
    logic [3:0] shb_idx_hi;
    logic [20:0] offset_nxt;
    logic [7:0] cell_rd [czd_pkg::SHB_COUNT];
    logic [7:0] cell_q [czd_pkg::SHB_COUNT];
    logic [7:0] rd_lo;
    logic [7:0] rd_hi;
    logic width_mis;
    logic resv;

    assign dev_env = (env_mode == czd_pkg::offchip_code_env);

    // ------------------------------------------------------------
    // Region decode
    // ------------------------------------------------------------
    always_comb
    begin
        rgn_nxt = czd_pkg::rgn_reserved;
        if (core_addr <= czd_pkg::LOW64_TOP)
        begin
            if (IS_BOOT && core_addr <= czd_pkg::BOOT_BASE_TOP)
                rgn_nxt = czd_pkg::rgn_base;
            else if (core_addr <= czd_pkg::BASE_LOW_TOP)
                rgn_nxt = IS_BOOT ? czd_pkg::rgn_exp : czd_pkg::rgn_base;
            else if (core_addr >= RAM_LO && core_addr <= czd_pkg::RAM_TOP)
                rgn_nxt = czd_pkg::rgn_ram;
            else if (core_addr >= czd_pkg::FCTL_LO && core_addr <= czd_pkg::FCTL_TOP)
                rgn_nxt = czd_pkg::rgn_flash_ctl;
            else if (core_addr >= czd_pkg::SHB_LO && core_addr <= czd_pkg::SHB_TOP)
                rgn_nxt = czd_pkg::rgn_shbios;
            else if (core_addr >= czd_pkg::BIU_LO && core_addr <= czd_pkg::BIU_TOP)
                rgn_nxt = czd_pkg::rgn_biu;
            else if (core_addr >= czd_pkg::DMA_LO && core_addr <= czd_pkg::DMA_TOP)
                rgn_nxt = czd_pkg::rgn_dma;
            else if (core_addr >= czd_pkg::IOX_LO && core_addr <= czd_pkg::IOX_TOP)
                rgn_nxt = czd_pkg::rgn_ioexp;
            else if (core_addr >= czd_pkg::MOD_LO)
                rgn_nxt = czd_pkg::rgn_modreg;
        end
        else if (core_addr <= czd_pkg::BASE_TOP)
        begin
            if (IS_BOOT)
                rgn_nxt = czd_pkg::rgn_exp;
            else if (dev_env)
                rgn_nxt = czd_pkg::rgn_base;
            else if (IS_BIG && core_addr <= czd_pkg::FAST_TOP)
                rgn_nxt = czd_pkg::rgn_base;
        end
        else
        begin
            rgn_nxt = czd_pkg::rgn_exp;
        end
    end

    assign in_base = (rgn_nxt == czd_pkg::rgn_base);
    assign shb_hit = (rgn_nxt == czd_pkg::rgn_shbios);
    assign resv = (rgn_nxt == czd_pkg::rgn_reserved);
    assign shb_idx = core_addr[3:0];
    assign shb_idx_hi = shb_idx + 4'h1;
    // Register block holds byte registers only; word access there is flagged
    assign width_mis = shb_hit && core_word;

    // Both alias windows of the expansion memory reach the same location
    always_comb
    begin
        offset_nxt = core_addr;
        if (rgn_nxt == czd_pkg::rgn_exp)
            offset_nxt = {1'b0, core_addr[19:0]};
    end

    // ------------------------------------------------------------
    // Access result, one cycle after the request
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            dec_valid_r <= 1'b0;
            region_r <= 4'h0;
            mem_offset_r <= 21'h000000;
            exp_sel_r <= 1'b0;
            reserved_hit_r <= 1'b0;
            width_err_r <= 1'b0;
        end
        else if (clk_en)
        begin
            // Byte and word requests take the same path in memory regions
            dec_valid_r <= core_req;
            region_r <= rgn_nxt;
            mem_offset_r <= offset_nxt;
            exp_sel_r <= core_req && (rgn_nxt == czd_pkg::rgn_exp);
            reserved_hit_r <= core_req && resv;
            width_err_r <= core_req && width_mis;
        end
    end

    // ------------------------------------------------------------
    // Base memory zone and placement
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            base_fast_r <= 1'b0;
            base_slow_r <= 1'b0;
            base_onchip_r <= 1'b0;
            base_offchip_r <= 1'b0;
        end
        else if (clk_en)
        begin
            base_fast_r <= core_req && in_base && core_addr <= czd_pkg::FAST_TOP;
            base_slow_r <= core_req && in_base && core_addr > czd_pkg::FAST_TOP;
            // Zone timing stays selected whether the memory is on or off chip
            base_onchip_r <= core_req && in_base && !dev_env;
            base_offchip_r <= core_req && in_base && dev_env;
        end
    end

    // ------------------------------------------------------------
    // Shared BIOS register block
    // ------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < czd_pkg::SHB_COUNT; gi++)
        begin : g_cell
            localparam czd_pkg::czd_acc_t ACC =
                (gi == czd_pkg::SHB_STATUS) ? czd_pkg::acc_w1c :
                (gi == czd_pkg::SHB_SPLIT) ? czd_pkg::acc_split :
                (gi == czd_pkg::SHB_INFO) ? czd_pkg::acc_ro : czd_pkg::acc_rw;
            logic wr_lo;
            logic wr_hi;
            logic [7:0] set_v;
            logic [7:0] src_v;
            assign wr_lo = core_req && core_we && shb_hit && shb_idx == 4'(gi);
            assign wr_hi = core_req && core_we && shb_hit && core_word && shb_idx_hi == 4'(gi);
            assign set_v = (gi == czd_pkg::SHB_STATUS)
                ? {6'h00, core_req && width_mis, core_req && resv} : 8'h00;
            assign src_v = (gi == czd_pkg::SHB_SPLIT) ? {4'h0, region_r}
                : {4'h0, 2'(VARIANT), env_mode};
            czd_reg_cell #(
                .ACC(ACC)
            ) u_cell (
                .sys_clk(sys_clk),
                .rst(rst),
                .clk_en(clk_en),
                .wr(wr_lo || wr_hi),
                .wdata(wr_hi ? core_wdata[15:8] : core_wdata[7:0]),
                .hw_set(set_v),
                .rd_src(src_v),
                .rdata(cell_rd[gi]),
                .store_r(cell_q[gi])
            );
        end
    endgenerate

    // Write side of the split register steers an outside control byte
    assign shbios_ctl = cell_q[czd_pkg::SHB_SPLIT];

    always_comb
    begin
        rd_lo = 8'h00;
        rd_hi = 8'h00;
        for (int k = 0; k < czd_pkg::SHB_COUNT; k++)
        begin
            if (shb_idx == 4'(k)) rd_lo = cell_rd[k];
            if (core_word && shb_idx_hi == 4'(k)) rd_hi = cell_rd[k];
        end
    end

    // Reads outside the block return zero; reserved bits read as zero
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst) core_rdata_r <= 16'h0000;
        else if (clk_en)
            core_rdata_r <= (core_req && !core_we && shb_hit) ? {rd_hi, rd_lo} : 16'h0000;
    end

endmodule : czd_decoder

//--- verification/czd_decoder_asserts.sv
// Concurrent checks on the ports of the core address zone decoder
module czd_decoder_asserts #(
    parameter int VARIANT = czd_pkg::VAR_FLASH64
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic clk_en,
    input wire logic core_req,
    input wire logic [20:0] core_addr,
    input wire logic core_we,
    input wire logic core_word,
    input wire czd_pkg::czd_env_t env_mode,
    input wire logic dec_valid_r,
    input wire logic [3:0] region_r,
    input wire logic base_fast_r,
    input wire logic base_slow_r,
    input wire logic base_onchip_r,
    input wire logic exp_sel_r,
    input wire logic [20:0] mem_offset_r,
    input wire logic width_err_r,
    input wire logic [15:0] core_rdata_r
);
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);
    localparam bit IS_BOOT = (VARIANT == czd_pkg::VAR_BOOTROM);
    logic tk;
    logic shb;
    logic base_q;
    logic rd_split;
    logic [19:0] a20;
    assign tk = clk_en && core_req;
    assign shb = (core_addr >= czd_pkg::SHB_LO) && (core_addr <= czd_pkg::SHB_TOP);
    assign base_q = region_r == czd_pkg::rgn_base;
    assign rd_split = tk && !core_we && !core_word && (core_addr == 21'h00F901);
    assign a20 = core_addr[19:0];
    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    a_req_gives_valid: assert property (tk |=> dec_valid_r)
        else $error("no decode pulse after a request");
    a_fast_zone_span: assert property ($past(tk) && base_q |->
        base_fast_r == ($past(core_addr) <= czd_pkg::FAST_TOP))
        else $error("fast zone flag wrong");
    a_slow_zone_span: assert property ($past(tk) && base_q |->
        base_slow_r == ($past(core_addr) > czd_pkg::FAST_TOP))
        else $error("slow zone flag wrong");
    a_onchip_by_env: assert property ($past(tk) && base_q |->
        base_onchip_r == ($past(env_mode) != czd_pkg::offchip_code_env))
        else $error("on-chip selection wrong");
    a_shbios_decode: assert property ($past(tk) |->
        (region_r == czd_pkg::rgn_shbios) == $past(shb))
        else $error("register block decode wrong");
    a_alias_offset: assert property (IS_BOOT && $past(tk) && exp_sel_r |->
        mem_offset_r == {1'b0, $past(a20)})
        else $error("expansion alias offset wrong");
    a_boot_base_small: assert property (IS_BOOT && $past(tk) && base_q |->
        $past(core_addr) <= czd_pkg::BOOT_BASE_TOP)
        else $error("base memory beyond 4K");
    a_split_read_src: assert property ($past(rd_split) |->
        core_rdata_r == {12'h000, $past(region_r)})
        else $error("split read returned wrong source");
    a_mem_width_free: assert property ($past(tk) && (base_q || exp_sel_r) |-> !width_err_r)
        else $error("memory access flagged as width error");
    c_slow_zone: cover property (base_slow_r);
    c_exp_hit: cover property (exp_sel_r);
    c_width_flag: cover property (width_err_r);
endmodule : czd_decoder_asserts

bind czd_decoder czd_decoder_asserts #(.VARIANT(VARIANT)) u_chk (.sys_clk, .rst, .clk_en,
    .core_req, .core_addr, .core_we, .core_word, .env_mode, .dec_valid_r, .region_r,
    .base_fast_r, .base_slow_r, .base_onchip_r, .exp_sel_r, .mem_offset_r, .width_err_r,
    .core_rdata_r);

//--- verification/czd_mem_model.sv
// Behavioural expansion memory addressed through the decoder's alias offset
module czd_mem_model (
    input wire logic sys_clk,
    input wire logic hit,
    input wire logic we,
    input wire logic [20:0] offset,
    input wire logic [7:0] wdata,
    output logic [7:0] rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] mem [0:4095];
    // Only the low 4K of the offset is kept: enough for the alias checks
    always_ff @(posedge sys_clk)
    begin
        if (hit && we)
            mem[offset[11:0]] <= wdata;
        if (hit && !we)
            rdata <= mem[offset[11:0]];
        else
            rdata <= ~rdata; // Released data inverts each cycle, so the stale value shows every other cycle
    end
endmodule : czd_mem_model

//--- verification/czd_decoder_tb.sv
// Self-checking bench for the core address zone decoder
`define CHK(n, e, g) \
    num_checks++; \
    if ((g) !== (e)) \
    begin \
        $display("[FAIL] %s exp %h got %h", n, e, g); \
        miscompares++; \
    end
module czd_decoder_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk = 1'b0, rst = 1'b1, clk_en = 1'b1, core_req = 1'b0, core_we = 1'b0;
    logic core_word = 1'b0;
    logic [20:0] core_addr = 21'h000000;
    logic [15:0] core_wdata = 16'h0000;
    czd_pkg::czd_env_t env_mode = czd_pkg::internal_run_env;
    logic dec_valid_r, base_fast_r, base_slow_r, base_onchip_r, base_offchip_r, exp_sel_r;
    logic reserved_hit_r, width_err_r, r_valid, r_offchip, r_exp;
    logic [3:0] region_r;
    logic [20:0] mem_offset_r, r_offset;
    logic [15:0] core_rdata_r;
    logic [7:0] shbios_ctl, m_rdata;
    int miscompares = 0, num_checks = 0, cyc = 0;
    always #4 sys_clk = ~sys_clk;
    czd_decoder #(.VARIANT(czd_pkg::VAR_FLASH128)) u_dut (.sys_clk, .rst, .clk_en, .core_req,
        .core_addr, .core_we, .core_word, .core_wdata, .env_mode, .dec_valid_r, .region_r,
        .base_fast_r, .base_slow_r, .base_onchip_r, .base_offchip_r, .exp_sel_r, .mem_offset_r,
        .reserved_hit_r, .width_err_r, .core_rdata_r, .shbios_ctl);
    czd_decoder #(.VARIANT(czd_pkg::VAR_BOOTROM)) u_rom (.sys_clk, .rst, .clk_en, .core_req,
        .core_addr, .core_we, .core_word, .core_wdata, .env_mode, .dec_valid_r(r_valid),
        .region_r(), .base_fast_r(), .base_slow_r(), .base_onchip_r(), .base_offchip_r(r_offchip),
        .exp_sel_r(r_exp), .mem_offset_r(r_offset), .reserved_hit_r(), .width_err_r(),
        .core_rdata_r(), .shbios_ctl());
    czd_mem_model u_mem (.sys_clk, .hit(r_valid && r_exp), .we(core_we), .offset(r_offset),
        .wdata(core_wdata[7:0]), .rdata(m_rdata));
    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    // One access; results are judged while they stand, before the next edge
    task automatic acc(input logic [20:0] a, input logic w, input logic wd, input logic [15:0] d);
        @(negedge sys_clk);
        {core_addr, core_we, core_word, core_wdata, core_req} = {a, w, wd, d, 1'b1};
        @(negedge sys_clk);
        core_req = 1'b0;
    endtask : acc
    task automatic t_zones;
        logic [20:0] a [4];
        a = '{21'h000100, 21'h01FFFF, 21'h020000, 21'h0FFFFF};
        for (int e = 0; e < 3; e++)
            for (int i = 0; i < 4; i++)
                if (e == 2 || i < 2)
                begin
                    // Fast zone is checked in all three environments, slow zone only off-chip
                    env_mode = czd_pkg::czd_env_t'(e);
                    acc(a[i], 1'b0, 1'b1, 16'h0000);
                    `CHK("fast", 1'(a[i] <= 21'h01FFFF), base_fast_r)
                    `CHK("slow", 1'(a[i] > 21'h01FFFF), base_slow_r)
                    `CHK("onchip", 1'(e != 2), base_onchip_r)
                    `CHK("offchip", 1'(e == 2), base_offchip_r)
                    `CHK("region", 4'(czd_pkg::rgn_base), region_r)
                    `CHK("width", 1'b0, width_err_r)
                end
        $display("t_zones done");
    endtask : t_zones
    task automatic t_boot_alias;
        env_mode = czd_pkg::offchip_code_env;
        acc(21'h000FFF, 1'b0, 1'b0, 16'h0000);
        `CHK("boot_base", 1'b1, r_offchip)
        acc(21'h001234, 1'b1, 1'b0, 16'h005A);
        `CHK("past_4k", 2'b01, {r_offchip, r_exp})
        acc(21'h101234, 1'b0, 1'b0, 16'h0000);
        `CHK("alias_off", 21'h001234, r_offset)
        @(negedge sys_clk);
        `CHK("alias_data", 8'h5A, m_rdata)
        $display("t_boot_alias done");
    endtask : t_boot_alias
    task automatic t_regs;
        acc(21'h00F902, 1'b0, 1'b0, 16'h0000);
        `CHK("info", 16'h0006, core_rdata_r)
        acc(21'h00F901, 1'b1, 1'b0, 16'h00A5);
        `CHK("split_w", 8'hA5, shbios_ctl)
        acc(21'h00F901, 1'b0, 1'b0, 16'h0000);
        `CHK("split_r", 16'h0005, core_rdata_r)
        acc(21'h00E000, 1'b0, 1'b0, 16'h0000);
        `CHK("rsv_hit", 1'b1, reserved_hit_r)
        acc(21'h00F904, 1'b0, 1'b1, 16'h0000);
        `CHK("width_hit", 1'b1, width_err_r)
        acc(21'h00F900, 1'b0, 1'b0, 16'h0000);
        `CHK("status", 16'h0003, core_rdata_r)
        acc(21'h00F900, 1'b1, 1'b0, 16'h0001);
        acc(21'h00F900, 1'b0, 1'b0, 16'h0000);
        `CHK("w1c_one", 16'h0002, core_rdata_r)
        acc(21'h00F905, 1'b1, 1'b0, 16'h003C);
        acc(21'h00F905, 1'b0, 1'b0, 16'h0000);
        `CHK("rw_cell", 16'h003C, core_rdata_r)
        $display("t_regs done");
    endtask : t_regs
    // Reset in mid-run clears the split write side and the status flags
    task automatic t_reset;
        @(negedge sys_clk);
        rst = 1'b1;
        @(negedge sys_clk);
        rst = 1'b0;
        `CHK("rst_ctl", 8'h00, shbios_ctl)
        `CHK("rst_valid", 1'b0, dec_valid_r)
        acc(21'h00F900, 1'b0, 1'b0, 16'h0000);
        `CHK("rst_status", 16'h0000, core_rdata_r)
        $display("t_reset done");
    endtask : t_reset
    // A request while the enable is low must leave every result and flag as it was
    task automatic t_hold;
        clk_en = 1'b0;
        acc(21'h00E000, 1'b0, 1'b0, 16'h0000);
        `CHK("hold_valid", 1'b1, dec_valid_r)
        `CHK("hold_rsv", 1'b0, reserved_hit_r)
        clk_en = 1'b1;
        acc(21'h00F900, 1'b0, 1'b0, 16'h0000);
        `CHK("hold_status", 16'h0000, core_rdata_r)
        $display("t_hold done");
    endtask : t_hold
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : print_verdict
    // ------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------
    // The run needs about 55 cycles; the ceiling leaves wide margin
    always @(posedge sys_clk)
    begin
        cyc++;
        if (cyc == 2000)
        begin
            miscompares++;
            print_verdict();
        end
    end
    initial
    begin
        repeat (4) @(posedge sys_clk);
        @(negedge sys_clk);
        rst = 1'b0;
        t_zones();
        t_boot_alias();
        t_regs();
        t_reset();
        t_hold();
        print_verdict();
    end
endmodule : czd_decoder_tb
